/* tglp_pkg.sv */
package tglp_pkg;
  localparam int REG_W = 16;
  localparam int DATA_W = 32;
  localparam int SAMP_W = 16;
  // printed offsets are word indices; byte address is index times four
  localparam logic [5:0] IDX_TONE1_FREQ = 6'h0D;
  localparam logic [5:0] IDX_TONE1_AMP = 6'h0E;
  localparam logic [5:0] IDX_TONE1_PHASE = 6'h0F;
  localparam logic [5:0] IDX_TONE2_FREQ = 6'h10;
  localparam logic [5:0] IDX_TONE2_AMP = 6'h11;
  localparam logic [5:0] IDX_TONE2_PHASE = 6'h12;
  localparam logic [5:0] IDX_RING_OFFSET = 6'h13;
  localparam logic [5:0] IDX_RING_FREQ = 6'h14;
  localparam logic [5:0] IDX_RING_AMP = 6'h15;
  localparam logic [5:0] IDX_RING_PHASE = 6'h16;
  localparam logic [5:0] IDX_METER_RAMP = 6'h17;
  localparam logic [5:0] IDX_METER_AMP = 6'h18;
  localparam logic [5:0] IDX_METER_FREQ = 6'h19;
  localparam logic [5:0] IDX_RX_GAIN = 6'h1A;
  localparam logic [5:0] IDX_TX_GAIN = 6'h1B;
  localparam logic [5:0] IDX_LC_HIGH = 6'h1C;
  localparam logic [5:0] IDX_RTRIP_THR = 6'h1D;
  localparam logic [5:0] IDX_CM_MIN = 6'h1E;
  localparam logic [5:0] IDX_CM_MAX = 6'h1F;
  localparam logic [5:0] IDX_PALARM_A = 6'h20;
  localparam logic [5:0] IDX_PALARM_B = 6'h21;
  localparam logic [5:0] IDX_PALARM_C = 6'h22;
  localparam logic [5:0] IDX_LC_FILT = 6'h23;
  localparam logic [5:0] IDX_RTRIP_FILT = 6'h24;
  localparam logic [5:0] IDX_TPOLE_A = 6'h25;
  localparam logic [5:0] IDX_TPOLE_B = 6'h26;
  localparam logic [5:0] IDX_TPOLE_C = 6'h27;
  localparam logic [5:0] IDX_RING_BIAS = 6'h28;
  localparam logic [5:0] IDX_OVERHEAD = 6'h29;
  localparam logic [5:0] IDX_RSVD = 6'h2A;
  localparam logic [5:0] IDX_LC_LOW = 6'h2B;
  localparam logic [5:0] IDX_CTRL = 6'h30;
  localparam logic [5:0] IDX_STATUS = 6'h31;
  localparam int CTRL_HYST_BIT = 0;
  localparam int STAT_LOOP_BIT = 0;
  localparam int STAT_CM_BIT = 1;
  localparam int GAIN_W = 12;
  localparam int GAIN_SHIFT = 10;
  localparam logic [GAIN_W-1:0] GAIN_MUTE = 12'h000;
  localparam logic [GAIN_W-1:0] GAIN_UNITY = 12'h400;
  localparam int RINGING_DC_OFFSET_W = 6;
  localparam int RING_STEP_MV = 1500;
  localparam int RING_MV_W = 17;
  typedef struct packed {
    logic [REG_W-1:0] freq;
    logic [REG_W-1:0] amp;
    logic [REG_W-1:0] phase;
  } tglp_osc_t;
  typedef struct packed {
    logic [REG_W-1:0] dc_offset;
    tglp_osc_t        osc;
  } tglp_ring_t;
  typedef struct packed {
    logic [REG_W-1:0] ramp;
    logic [REG_W-1:0] amp;
    logic [REG_W-1:0] freq;
  } tglp_meter_t;
  typedef struct packed {
    logic                     valid;
    logic signed [SAMP_W-1:0] data;
  } tglp_sample_t;
endpackage

/* tglp_gain_scaler.sv */
`timescale 1ns/1ps
module tglp_gain_scaler
  import tglp_pkg::*;
(
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  // gain word and samples
  input  wire logic [GAIN_W-1:0] i_gain,
  input  wire tglp_sample_t      i_samp,
  output tglp_sample_t           o_samp
);
  localparam int PROD_W = SAMP_W + GAIN_W;
  localparam logic signed [PROD_W-1:0] SAT_HI = PROD_W'((1 <<< (SAMP_W - 1)) - 1);
  localparam logic signed [PROD_W-1:0] SAT_LO = -PROD_W'(1 <<< (SAMP_W - 1));
  logic signed [PROD_W-1:0] prod;
  logic signed [PROD_W-1:0] scaled;
  tglp_sample_t             samp_ff;
  // widen both operands first so the product is not cut to the sample width
  assign prod = PROD_W'(i_samp.data) * PROD_W'($signed(i_gain));
  assign scaled = prod >>> GAIN_SHIFT;
  // saturate instead of wrapping: near 6 dB a full-scale sample would overflow
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      samp_ff <= '0;
    end else begin
      samp_ff.valid <= i_samp.valid;
      if (i_gain == GAIN_MUTE) begin
        samp_ff.data <= '0;
      end else if (scaled > SAT_HI) begin
        samp_ff.data <= SAT_HI[SAMP_W-1:0];
      end else if (scaled < SAT_LO) begin
        samp_ff.data <= SAT_LO[SAMP_W-1:0];
      end else begin
        samp_ff.data <= scaled[SAMP_W-1:0];
      end
    end
  end
  assign o_samp = samp_ff;
  property p_gain_mute;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_gain == GAIN_MUTE) |=> (o_samp.data == '0);
  endproperty
  a_gain_mute: assert property (p_gain_mute) else $error("muted path not silent");
  property p_gain_unity;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_gain == GAIN_UNITY) |=> (o_samp.data == $past(i_samp.data));
  endproperty
  a_gain_unity: assert property (p_gain_unity) else $error("unity gain altered sample");
endmodule // tglp_gain_scaler

/* tglp_hyst_cmp.sv */
`timescale 1ns/1ps
module tglp_hyst_cmp
  import tglp_pkg::*;
(
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  // measurement and thresholds, all signed words
  input  wire logic [REG_W-1:0] i_meas,
  input  wire logic [REG_W-1:0] i_high,
  input  wire logic [REG_W-1:0] i_low,
  input  wire logic             i_hyst_en,
  // detector state
  output logic                  o_state
);
  logic above;
  logic below;
  logic state_ff;
  assign above = $signed(i_meas) > $signed(i_high);
  assign below = $signed(i_meas) < $signed(i_low);
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= 1'b0;
    end else if (!i_hyst_en) begin
      state_ff <= above;
    end else if (above) begin
      state_ff <= 1'b1;
    end else if (below) begin
      state_ff <= 1'b0;
    end
  end
  assign o_state = state_ff;
  property p_hyst_hold;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_hyst_en && o_state && !below) |=> o_state;
  endproperty
  a_hyst_hold: assert property (p_hyst_hold) else $error("closure lost above low bound");
  property p_no_hyst;
    @(posedge i_sys_clk) disable iff (!i_rst_n)
      !i_hyst_en |=> (o_state == $past(above));
  endproperty
  a_no_hyst: assert property (p_no_hyst) else $error("plain compare wrong");
endmodule // tglp_hyst_cmp

/* tglp_param_bank.sv */
`timescale 1ns/1ps
// What this block does
// - unused bits are kept as storage; software should write them zero
// - coefficient and threshold words are treated as two's complement signed
// - receive gain multiplies receive samples; 0x400 unity, 0x7FF about 6 dB
// - transmit gain multiplies transmit samples with the same coding
// - gain word zero mutes its path entirely
// - ringing dc offset adds 1.5 V per code, 0 to 94.5 V
// - tone one takes frequency, amplitude and phase from three words
// - tone two takes frequency, amplitude and phase from three own words
// - ringing uses its own frequency, amplitude, phase words plus dc offset
// - metering uses ramp rate, amplitude and frequency words
// - loop closure high and low thresholds; low bound only with hysteresis
// - exceeding either common mode threshold raises the speed-up flag
module tglp_param_bank
  import tglp_pkg::*;
#(
  parameter int APB_AW = 8
) (
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_resetn,
  // apb slave
  input  wire logic [APB_AW-1:0] i_paddr,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [DATA_W-1:0] i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic [DATA_W-1:0]      o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  // sample paths
  input  wire tglp_sample_t      i_rx_samp,
  input  wire tglp_sample_t      i_tx_samp,
  output tglp_sample_t           o_rx_samp,
  output tglp_sample_t           o_tx_samp,
  // line measurements
  input  wire logic [REG_W-1:0]  i_loop_current,
  input  wire logic [REG_W-1:0]  i_cm_voltage,
  output logic                   o_loop_closed,
  output logic                   o_cm_speedup,
  // generator coefficients
  output tglp_osc_t              o_tone1,
  output tglp_osc_t              o_tone2,
  output tglp_ring_t             o_ring,
  output logic [RING_MV_W-1:0]   o_ring_offset_mv,
  output tglp_meter_t            o_meter,
  // line control words
  output logic [REG_W-1:0]       o_ring_trip_thr,
  output logic [REG_W-1:0]       o_ring_trip_filt,
  output logic [REG_W-1:0]       o_loop_filt
);
  localparam logic [5:0] IDX_FIRST = IDX_TONE1_FREQ;
  localparam logic [5:0] IDX_LAST = IDX_LC_LOW;

  logic                   rst_meta_ff;
  logic                   rst_n;
  logic [REG_W-1:0]       regs_ff [IDX_FIRST:IDX_LAST];
  logic                   hyst_en_ff;
  logic                   cm_speedup_ff;
  logic                   loop_closed;
  logic [DATA_W-1:0]      prdata_ff;
  logic [DATA_W-1:0]      nxt_prdata;
  logic                   pready_ff;
  logic                   pslverr_ff;
  logic                   nxt_pslverr;
  logic [5:0]             idx;
  logic                   in_bank;
  logic                   setup;
  logic                   wr_en;
  logic [REG_W-1:0]       wr_mask;
  tglp_osc_t              tone1_ff;
  tglp_osc_t              tone2_ff;
  tglp_ring_t             ring_ff;
  tglp_meter_t            meter_ff;
  logic [RING_MV_W-1:0]   ring_mv_ff;
  logic [REG_W-1:0]       rtrip_thr_ff;
  logic [REG_W-1:0]       rtrip_filt_ff;
  logic [REG_W-1:0]       loop_filt_ff;

  // reset release through two flops; assertion is immediate
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  // address decode
  assign idx     = i_paddr[7:2];
  assign in_bank = (idx >= IDX_FIRST) && (idx <= IDX_LAST);
  assign setup   = i_psel && !i_penable;
  assign wr_en   = i_psel && i_penable && pready_ff && i_pwrite && !pslverr_ff;
  assign wr_mask = {{8{i_pstrb[1]}}, {8{i_pstrb[0]}}};

  always_comb begin
    nxt_prdata  = '0;
    nxt_pslverr = 1'b0;
    if (i_paddr[1:0] != 2'b00) begin
      nxt_pslverr = 1'b1;
    end else if (in_bank) begin
      // reserved slot reads zero and ignores writes
      if (idx != IDX_RSVD) begin
        nxt_prdata[REG_W-1:0] = regs_ff[idx];
      end
    end else if (idx == IDX_CTRL) begin
      nxt_prdata[CTRL_HYST_BIT] = hyst_en_ff;
    end else if (idx == IDX_STATUS) begin
      nxt_prdata[STAT_LOOP_BIT] = loop_closed;
      nxt_prdata[STAT_CM_BIT]   = cm_speedup_ff;
    end else begin
      nxt_pslverr = 1'b1;
    end
  end

  // answer prepared in setup so pready and data come from flops, no wait states
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup && nxt_pslverr;
      if (setup && !i_pwrite) begin
        prdata_ff <= nxt_prdata;
      end else if (!i_psel) begin
        prdata_ff <= '0;
      end
    end
  end

  // storage words: cleared on reset for determinism, but software must load them
  for (genvar g = IDX_FIRST; g <= IDX_LAST; g++) begin : g_word
    always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        regs_ff[g] <= '0;
      end else if (wr_en && idx == 6'(g) && 6'(g) != IDX_RSVD) begin
        // every bit kept, including unused ones
        regs_ff[g] <= (regs_ff[g] & ~wr_mask) | (i_pwdata[REG_W-1:0] & wr_mask);
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hyst_en_ff <= 1'b0;
    end else if (wr_en && idx == IDX_CTRL && i_pstrb[0]) begin
      hyst_en_ff <= i_pwdata[CTRL_HYST_BIT];
    end
  end

  // generator coefficient copies
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tone1_ff <= '0;
      tone2_ff <= '0;
    end else begin
      tone1_ff.freq  <= regs_ff[IDX_TONE1_FREQ];
      tone1_ff.amp   <= regs_ff[IDX_TONE1_AMP];
      tone1_ff.phase <= regs_ff[IDX_TONE1_PHASE];
      tone2_ff.freq  <= regs_ff[IDX_TONE2_FREQ];
      tone2_ff.amp   <= regs_ff[IDX_TONE2_AMP];
      tone2_ff.phase <= regs_ff[IDX_TONE2_PHASE];
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ring_ff    <= '0;
      ring_mv_ff <= '0;
    end else begin
      ring_ff.dc_offset <= regs_ff[IDX_RING_OFFSET];
      ring_ff.osc.freq  <= regs_ff[IDX_RING_FREQ];
      ring_ff.osc.amp   <= regs_ff[IDX_RING_AMP];
      ring_ff.osc.phase <= regs_ff[IDX_RING_PHASE];
      // offset voltage in millivolts from the registered code
      ring_mv_ff <= RING_MV_W'(ring_ff.dc_offset[RINGING_DC_OFFSET_W-1:0] * RING_STEP_MV);
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      meter_ff <= '0;
    end else begin
      meter_ff.ramp <= regs_ff[IDX_METER_RAMP];
      meter_ff.amp  <= regs_ff[IDX_METER_AMP];
      meter_ff.freq <= regs_ff[IDX_METER_FREQ];
    end
  end

  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rtrip_thr_ff  <= '0;
      rtrip_filt_ff <= '0;
      loop_filt_ff  <= '0;
    end else begin
      rtrip_thr_ff  <= regs_ff[IDX_RTRIP_THR];
      rtrip_filt_ff <= regs_ff[IDX_RTRIP_FILT];
      loop_filt_ff  <= regs_ff[IDX_LC_FILT];
    end
  end

  // speed-up on either side of the common mode window
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cm_speedup_ff <= 1'b0;
    end else begin
      cm_speedup_ff <= ($signed(i_cm_voltage) > $signed(regs_ff[IDX_CM_MAX])) ||
                       ($signed(i_cm_voltage) < -$signed(regs_ff[IDX_CM_MIN]));
    end
  end

  tglp_hyst_cmp u_loop_cmp (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (rst_n),
    .i_meas    (i_loop_current),
    .i_high    (regs_ff[IDX_LC_HIGH]),
    .i_low     (regs_ff[IDX_LC_LOW]),
    .i_hyst_en (hyst_en_ff),
    .o_state   (loop_closed)
  );

  tglp_gain_scaler u_rx_gain (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (rst_n),
    .i_gain    (regs_ff[IDX_RX_GAIN][GAIN_W-1:0]),
    .i_samp    (i_rx_samp),
    .o_samp    (o_rx_samp)
  );

  tglp_gain_scaler u_tx_gain (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (rst_n),
    .i_gain    (regs_ff[IDX_TX_GAIN][GAIN_W-1:0]),
    .i_samp    (i_tx_samp),
    .o_samp    (o_tx_samp)
  );

  assign o_prdata         = prdata_ff;
  assign o_pready         = pready_ff;
  assign o_pslverr        = pslverr_ff;
  assign o_loop_closed    = loop_closed;
  assign o_cm_speedup     = cm_speedup_ff;
  assign o_tone1          = tone1_ff;
  assign o_tone2          = tone2_ff;
  assign o_ring           = ring_ff;
  assign o_ring_offset_mv = ring_mv_ff;
  assign o_meter          = meter_ff;
  assign o_ring_trip_thr  = rtrip_thr_ff;
  assign o_ring_trip_filt = rtrip_filt_ff;
  assign o_loop_filt      = loop_filt_ff;

  property p_write_read;
    @(posedge i_sys_clk) disable iff (!rst_n)
      (wr_en && idx == IDX_RX_GAIN && i_pstrb[1:0] == 2'b11)
        |=> (regs_ff[IDX_RX_GAIN] == $past(i_pwdata[REG_W-1:0]));
  endproperty
  a_write_read: assert property (p_write_read) else $error("word not stored in full");

  property p_tone1_path;
    @(posedge i_sys_clk) disable iff (!rst_n)
      (wr_en && idx == IDX_TONE1_AMP && i_pstrb[1:0] == 2'b11)
        |=> ##1 (o_tone1.amp == $past(i_pwdata[REG_W-1:0], 2));
  endproperty
  a_tone1_path: assert property (p_tone1_path) else $error("tone one amplitude late");

  property p_ring_mv;
    @(posedge i_sys_clk) disable iff (!rst_n)
      ##1 (o_ring_offset_mv ==
           RING_MV_W'($past(regs_ff[IDX_RING_OFFSET][RINGING_DC_OFFSET_W-1:0], 2) * RING_STEP_MV));
  endproperty
  a_ring_mv: assert property (p_ring_mv) else $error("ring offset scale wrong");

  property p_meter_path;
    @(posedge i_sys_clk) disable iff (!rst_n)
      1'b1 |=> (o_meter.ramp == $past(regs_ff[IDX_METER_RAMP]));
  endproperty
  a_meter_path: assert property (p_meter_path) else $error("ramp copy wrong");

  property p_ready_timing;
    @(posedge i_sys_clk) disable iff (!rst_n)
      (i_psel && !i_penable) |=> (o_pready && !$past(o_pready));
  endproperty
  a_ready_timing: assert property (p_ready_timing) else $error("pready not one after setup");

  property p_rsvd_zero;
    @(posedge i_sys_clk) disable iff (!rst_n)
      (setup && !i_pwrite && idx == IDX_RSVD && i_paddr[1:0] == 2'b00)
        |=> (o_prdata == '0 && !o_pslverr);
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved slot misbehaves");

  property p_cm_speedup;
    @(posedge i_sys_clk) disable iff (!rst_n)
      ($signed(i_cm_voltage) > $signed(regs_ff[IDX_CM_MAX])) |=> o_cm_speedup;
  endproperty
  a_cm_speedup: assert property (p_cm_speedup) else $error("speed-up missed");

  property p_tx_mute;
    @(posedge i_sys_clk) disable iff (!rst_n)
      (regs_ff[IDX_TX_GAIN][GAIN_W-1:0] == GAIN_MUTE && i_tx_samp.valid)
        |=> (o_tx_samp.valid && o_tx_samp.data == '0);
  endproperty
  a_tx_mute: assert property (p_tx_mute) else $error("transmit not muted");

  property p_tone2_freq;
    @(posedge i_sys_clk) disable iff (!rst_n)
      1'b1 |=> (o_tone2.freq == $past(regs_ff[IDX_TONE2_FREQ]));
  endproperty
  a_tone2_freq: assert property (p_tone2_freq) else $error("tone two copy wrong");

  property p_ring_freq;
    @(posedge i_sys_clk) disable iff (!rst_n)
      1'b1 |=> (o_ring.osc.freq == $past(regs_ff[IDX_RING_FREQ]));
  endproperty
  a_ring_freq: assert property (p_ring_freq) else $error("ring copy wrong");

  property p_ctrl_write;
    @(posedge i_sys_clk) disable iff (!rst_n)
      (wr_en && idx == IDX_CTRL && i_pstrb[0])
        |=> (hyst_en_ff == $past(i_pwdata[CTRL_HYST_BIT]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("enable not stored");

  property p_ready_pulse;
    @(posedge i_sys_clk) disable iff (!rst_n)
      o_pready |=> !o_pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");

  property p_rdata_upper;
    @(posedge i_sys_clk) disable iff (!rst_n)
      o_pready |-> (o_prdata[DATA_W-1:REG_W] == '0);
  endproperty
  a_rdata_upper: assert property (p_rdata_upper) else $error("upper read bits set");

  property p_cm_low;
    @(posedge i_sys_clk) disable iff (!rst_n)
      ($signed(i_cm_voltage) < -$signed(regs_ff[IDX_CM_MIN])) |=> o_cm_speedup;
  endproperty
  a_cm_low: assert property (p_cm_low) else $error("low speed-up missed");
endmodule // tglp_param_bank

/* tglp_param_bank_tb_top.sv */
`timescale 1ns/1ps
module tglp_param_bank_tb_top
  import tglp_pkg::*;
;
  // clock and reset
  logic                 sys_clk;
  logic                 resetn;
  // apb
  logic [7:0]           paddr;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [DATA_W-1:0]    pwdata;
  logic [3:0]           pstrb;
  logic [DATA_W-1:0]    prdata;
  logic                 pready;
  logic                 pslverr;
  // datapath and line side
  tglp_sample_t         rx_in;
  tglp_sample_t         tx_in;
  tglp_sample_t         rx_out;
  tglp_sample_t         tx_out;
  logic [REG_W-1:0]     loop_current;
  logic [REG_W-1:0]     cm_voltage;
  logic                 loop_closed;
  logic                 cm_speedup;
  tglp_osc_t            tone1;
  tglp_osc_t            tone2;
  tglp_ring_t           ring;
  logic [RING_MV_W-1:0] ring_mv;
  tglp_meter_t          meter;
  logic [REG_W-1:0]     rt_thr;
  logic [REG_W-1:0]     rt_filt;
  logic [REG_W-1:0]     lc_filt;
  int                   error_cnt;
  int                   n_compared;

  tglp_param_bank u_tglp_param_bank (
    .i_sys_clk        (sys_clk),
    .i_resetn         (resetn),
    .i_paddr          (paddr),
    .i_psel           (psel),
    .i_penable        (penable),
    .i_pwrite         (pwrite),
    .i_pwdata         (pwdata),
    .i_pstrb          (pstrb),
    .o_prdata         (prdata),
    .o_pready         (pready),
    .o_pslverr        (pslverr),
    .i_rx_samp        (rx_in),
    .i_tx_samp        (tx_in),
    .o_rx_samp        (rx_out),
    .o_tx_samp        (tx_out),
    .i_loop_current   (loop_current),
    .i_cm_voltage     (cm_voltage),
    .o_loop_closed    (loop_closed),
    .o_cm_speedup     (cm_speedup),
    .o_tone1          (tone1),
    .o_tone2          (tone2),
    .o_ring           (ring),
    .o_ring_offset_mv (ring_mv),
    .o_meter          (meter),
    .o_ring_trip_thr  (rt_thr),
    .o_ring_trip_filt (rt_filt),
    .o_loop_filt      (lc_filt)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // master waits for pready, never assumes a latency; the watchdog bounds the wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic err);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= wr;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, {idx, 2'b00}, d, 4'hF, rd, err);
    chk(err, 1'b0);
  endtask

  task automatic rdx(input logic [7:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, 4'hF, rd, err);
    chk(rd, exp);
    chk(err, experr);
  endtask

  function automatic logic [15:0] pat(input int i);
    return 16'(i * 1057) ^ 16'h8A5C;
  endfunction

  // gain is a signed 12-bit multiplier with ten fraction bits
  function automatic logic [15:0] scale(input logic [11:0] g, input logic signed [15:0] x);
    longint p;
    if (g == 12'h000) return 16'h0000;
    p = (longint'($signed(g)) * longint'(x)) >>> 10;
    if (p > 32767) p = 32767;
    if (p < -32768) p = -32768;
    return 16'(p);
  endfunction

  task automatic t_bank();
    int i;
    for (i = 13; i <= 43; i++) wr(6'(i), {16'hFFFF, pat(i)});
    for (i = 13; i <= 43; i++) rdx({6'(i), 2'b00}, (i == 42) ? 32'h0 : {16'h0, pat(i)}, 1'b0);
    chk(tone1, {pat(13), pat(14), pat(15)});
    chk(tone2, {pat(16), pat(17), pat(18)});
    chk(ring, {pat(19), pat(20), pat(21), pat(22)});
    chk(meter, {pat(23), pat(24), pat(25)});
    chk({rt_thr, rt_filt, lc_filt}, {pat(29), pat(36), pat(35)});
    for (i = 0; i < 3; i++) begin
      wr(IDX_RING_OFFSET, (i == 2) ? 32'h3F : 32'(i));
      repeat (3) @(posedge sys_clk);
      chk(ring_mv, (i == 2) ? 64'd94500 : 64'(i * 1500));
    end
  endtask

  task automatic t_errors();
    logic [31:0] rd;
    logic        err;
    rdx(8'h14, 32'h0, 1'b1);
    rdx(8'h35, 32'h0, 1'b1);
    rdx(8'hB0, 32'h0, 1'b1);
    wr(IDX_RSVD, 32'h0000_1234);
    rdx({IDX_RSVD, 2'b00}, 32'h0, 1'b0);
    // only the low lane is enabled, the high byte must survive
    apb(1'b1, {IDX_TONE1_FREQ, 2'b00}, 32'h0000_77EE, 4'h1, rd, err);
    rdx({IDX_TONE1_FREQ, 2'b00}, {16'h0, pat(13) & 16'hFF00 | 16'h00EE}, 1'b0);
  endtask

  task automatic t_gain();
    logic [11:0]        g[5]  = '{12'h400, 12'h7FF, 12'h7FF, 12'h000, 12'hC00};
    logic signed [15:0] x[5]  = '{-16'sd1234, 16'sd1000, -16'sd20000, 16'sd12345, 16'sd500};
    int k;
    for (k = 0; k < 5; k++) begin
      wr(IDX_RX_GAIN, {20'h0, g[k]});
      wr(IDX_TX_GAIN, {20'h0, g[(k + 1) % 5]});
      @(posedge sys_clk);
      rx_in <= '{valid: 1'b1, data: x[k]};
      tx_in <= '{valid: 1'b1, data: x[(k + 2) % 5]};
      @(posedge sys_clk);
      #1;
      chk(rx_out, {1'b1, scale(g[k], x[k])});
      chk(tx_out, {1'b1, scale(g[(k + 1) % 5], x[(k + 2) % 5])});
      if (g[k] == 12'h000) chk(rx_out.data, 16'h0);
    end
  endtask

  task automatic lc_step(input logic [15:0] m, input logic exp);
    @(posedge sys_clk);
    loop_current <= m;
    repeat (4) @(posedge sys_clk);
    chk(loop_closed, exp);
  endtask

  task automatic cm_step(input logic [15:0] v, input logic exp);
    @(posedge sys_clk);
    cm_voltage <= v;
    repeat (4) @(posedge sys_clk);
    chk(cm_speedup, exp);
  endtask

  task automatic t_line();
    wr(IDX_LC_HIGH, 32'h0100);
    wr(IDX_LC_LOW, 32'h0040);
    wr(IDX_CTRL, 32'h0);
    lc_step(16'h0080, 1'b0);
    lc_step(16'h0200, 1'b1);
    lc_step(16'h0080, 1'b0);
    lc_step(16'hFF00, 1'b0);
    wr(IDX_CTRL, 32'h1);
    lc_step(16'h0200, 1'b1);
    lc_step(16'h0080, 1'b1);
    rdx({IDX_CTRL, 2'b00}, 32'h1, 1'b0);
    lc_step(16'h0020, 1'b0);
    lc_step(16'h0080, 1'b0);
    wr(IDX_CM_MAX, 32'h0100);
    wr(IDX_CM_MIN, 32'h0080);
    cm_step(16'h0050, 1'b0);
    cm_step(16'h0150, 1'b1);
    cm_step(16'h0100, 1'b0);
    cm_step(16'hFF00, 1'b1);
    rdx({IDX_STATUS, 2'b00}, 32'h2, 1'b0);
    cm_step(16'hFF80, 1'b0);
    cm_step(16'hFFA0, 1'b0);
  endtask

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // whole run needs well under 10k cycles
  initial begin
    #200000;
    error_cnt++;
    $display("BAD t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    report_and_stop();
  end

  initial begin
    error_cnt = 0;
    n_compared = 0;
    resetn = 1'b0;
    paddr = 8'h00;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    rx_in = '0;
    tx_in = '0;
    loop_current = 16'h0;
    cm_voltage = 16'h0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    // two-flop release plus the allowed setup edge
    repeat (3) @(posedge sys_clk);
    t_bank();
    t_errors();
    t_gain();
    t_line();
    report_and_stop();
  end
endmodule // tglp_param_bank_tb_top
